// ---- design/vvt_consts.vh ----
`ifndef VVT_CONSTS_VH
`define VVT_CONSTS_VH

// Register byte addresses
`define VVT_ADDR_LINE_END 32'hC0000030
`define VVT_ADDR_VSYNC_END 32'hC0000040
`define VVT_ADDR_VBLANK_END 32'hC0000050
`define VVT_ADDR_VBLANK_START 32'hC0000060
`define VVT_ADDR_FRAME_END 32'hC0000070
`define VVT_ADDR_IRQ_LINE 32'hC0000080
`define VVT_ADDR_CONTROL 32'hC0000090
`define VVT_ADDR_STATUS 32'hC00000A0
`define VVT_ADDR_PENDING 32'hC0000120
`define VVT_ADDR_LINE_COUNTER 32'hC00001D0

// Field positions
`define VVT_CTRL_INTERLACE 0
`define VVT_CTRL_EXT_VIDEO_SEL 1
`define VVT_CTRL_HSYNC_DIR 2
`define VVT_PEND_DISPLAY_IRQ 10
`define VVT_STAT_VSYNC 0
`define VVT_STAT_VBLANK 1
`define VVT_STAT_ODD_FIELD 2
`define VVT_STAT_BLANK 3

// Reset values
`define VVT_RST_TIMING 16'h0000
`define VVT_RST_CONTROL 3'h6
`define VVT_RST_ZERO32 32'h00000000

`endif

// ---- design/vvt_sync.v ----
`timescale 1ns/1ns
// Two-flop synchroniser per bit, plus a third stage for edge detection
module vvt_sync #(
  parameter WIDTH = 3
) (
  input wire sys_clk_i,
  input wire rst_b_i,
  input wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] level_o,
  output wire [WIDTH-1:0] rise_o,
  output wire [WIDTH-1:0] fall_o
);
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
      reg meta;
      reg stable;
      reg last;
      // First stage feeds only the second stage
      always @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
          meta <= 1'b1;
          stable <= 1'b1;
          last <= 1'b1;
        end else begin
          meta <= async_i[gi];
          stable <= meta;
          last <= stable;
        end
      end
      assign level_o[gi] = stable;
      assign rise_o[gi] = stable & ~last;
      assign fall_o[gi] = ~stable & last;
    end
  endgenerate
endmodule

// ---- design/vvt_vertical_timing.v ----
`timescale 1ns/1ns
`include "vvt_consts.vh"
module vvt_vertical_timing (
  input wire sys_clk_i,
  input wire rst_b_i,
  input wire [31:0] reg_addr_i,
  input wire [15:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [15:0] reg_rdata_o,
  input wire video_clock_i,
  input wire vsync_i,
  output reg vsync_o,
  output reg vsync_oe_o,
  input wire hsync_i,
  output reg hsync_o,
  input wire hblank_i,
  output reg blank_b_o,
  output reg display_irq_o,
  output reg [15:0] dot_counter_o
);
  reg [15:0] line_end_value;
  reg [15:0] vsync_end_line;
  reg [15:0] vblank_end_line;
  reg [15:0] vblank_start_line;
  reg [15:0] frame_end_line;
  reg [15:0] display_irq_line;
  reg [2:0] control;
  reg [15:0] line_counter;
  reg [15:0] dot_counter;
  reg vsync_state;
  reg vblank;
  reg odd_field;
  reg display_irq_pending;
  reg irq_match_q;
  reg frame_pend;
  reg frame_done;
  reg [15:0] next_line;
  reg [15:0] next_dot;
  reg next_vsync;
  reg next_odd;
  reg next_pend;
  reg next_done;
  wire [2:0] pin_level;
  wire [2:0] pin_rise;
  wire [2:0] pin_fall;
  wire video_clock_fall;
  wire vs_in_fall;
  wire vs_in_rise;
  wire hs_in_fall;
  wire interlace;
  wire ext_video;
  wire hs_input;
  wire dot_end;
  wire dot_half;
  wire frame_hit;
  wire sync_end_hit;
  wire blank_evt;
  wire irq_match;
  wire wr_line;

  // Video clock, external vertical sync and horizontal sync pins
  vvt_sync #(
    .WIDTH(3)
  ) u_sync (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .async_i({hsync_i, vsync_i, video_clock_i}),
    .level_o(pin_level),
    .rise_o(pin_rise),
    .fall_o(pin_fall)
  );

  assign video_clock_fall = pin_fall[0];
  assign vs_in_fall = pin_fall[1];
  assign vs_in_rise = pin_rise[1];
  assign hs_in_fall = pin_fall[2];
  assign interlace = control[`VVT_CTRL_INTERLACE];
  assign ext_video = ~control[`VVT_CTRL_EXT_VIDEO_SEL];
  assign hs_input = ~control[`VVT_CTRL_HSYNC_DIR];

  // Horizontal comparisons used by the vertical logic
  assign dot_end = (dot_counter == line_end_value);
  assign dot_half = (dot_counter == {1'b0, line_end_value[15:1]});

  // Frame end match: even interlaced field closes at the half line
  assign frame_hit = video_clock_fall && (line_counter == frame_end_line) &&
                     ((interlace && !odd_field) ? dot_half : dot_end);

  // Sync end match: odd field next closes at the half line
  assign sync_end_hit = video_clock_fall && (line_counter == vsync_end_line) &&
                        ((interlace && odd_field) ? dot_half : dot_end);

  // Blanking edges: external horizontal sync when slaved with hsync as input, else the line end
  assign blank_evt = (ext_video && hs_input) ? hs_in_fall : (video_clock_fall && dot_end);

  assign irq_match = (line_counter == display_irq_line);
  assign wr_line = reg_wr_i && (reg_addr_i == `VVT_ADDR_LINE_COUNTER);

  // Next values for dot counter, line counter, sync and field state
  always @* begin
    next_dot = dot_counter;
    next_line = line_counter;
    next_vsync = vsync_state;
    next_odd = odd_field;
    next_pend = frame_pend;
    next_done = frame_done;
    if (wr_line) begin
      next_line = reg_wdata_i;
    end
    if (video_clock_fall) begin
      if (dot_end) begin
        next_dot = 16'h0000;
      end else begin
        next_dot = dot_counter + 16'h0001;
      end
    end
    if (!ext_video) begin
      if (frame_hit) begin
        next_line = 16'h0000;
        next_vsync = 1'b0;
        next_odd = interlace ? ~odd_field : 1'b0;
      end else if (video_clock_fall && dot_end) begin
        next_line = line_counter + 16'h0001;
      end
      if (sync_end_hit && !frame_hit) begin
        next_vsync = 1'b1;
      end
      next_pend = 1'b0;
      next_done = 1'b0;
    end else begin
      next_vsync = pin_level[1];
      if (frame_pend && video_clock_fall) begin
        next_line = 16'h0000;
        next_pend = 1'b0;
        next_done = 1'b1;
      end else if (vs_in_fall && !frame_done) begin
        next_line = 16'h0000;
        next_done = 1'b1;
      end else if (video_clock_fall && dot_end) begin
        next_line = line_counter + 16'h0001;
      end
      if (!frame_done && !frame_pend && (line_counter == frame_end_line) && blank_evt) begin
        next_pend = 1'b1;
      end
      if (vs_in_rise) begin
        next_done = 1'b0;
      end
    end
  end

  // Video timing state
  always @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      dot_counter <= `VVT_RST_TIMING;
      line_counter <= `VVT_RST_TIMING;
      vsync_state <= 1'b1;
      odd_field <= 1'b0;
      frame_pend <= 1'b0;
      frame_done <= 1'b0;
    end else begin
      dot_counter <= next_dot;
      line_counter <= next_line;
      vsync_state <= next_vsync;
      odd_field <= next_odd;
      frame_pend <= next_pend;
      frame_done <= next_done;
    end
  end

  // Internal vertical blank; start wins if both values coincide
  always @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      vblank <= 1'b0;
    end else if (blank_evt && (line_counter == vblank_start_line)) begin
      vblank <= 1'b1;
    end else if (blank_evt && (line_counter == vblank_end_line)) begin
      vblank <= 1'b0;
    end
  end

  // Display interrupt latch: set on entering a match, set beats clear
  always @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      irq_match_q <= 1'b0;
      display_irq_pending <= 1'b0;
    end else begin
      irq_match_q <= irq_match;
      if (irq_match && !irq_match_q) begin
        display_irq_pending <= 1'b1;
      end else if (reg_wr_i && (reg_addr_i == `VVT_ADDR_PENDING) &&
                   !reg_wdata_i[`VVT_PEND_DISPLAY_IRQ]) begin
        display_irq_pending <= 1'b0;
      end
    end
  end

  // Software-written timing and control registers
  always @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      line_end_value <= `VVT_RST_TIMING;
      vsync_end_line <= `VVT_RST_TIMING;
      vblank_end_line <= `VVT_RST_TIMING;
      vblank_start_line <= `VVT_RST_TIMING;
      frame_end_line <= `VVT_RST_TIMING;
      display_irq_line <= `VVT_RST_TIMING;
      control <= `VVT_RST_CONTROL;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `VVT_ADDR_LINE_END: begin
          line_end_value <= reg_wdata_i;
        end
        `VVT_ADDR_VSYNC_END: begin
          vsync_end_line <= reg_wdata_i;
        end
        `VVT_ADDR_VBLANK_END: begin
          vblank_end_line <= reg_wdata_i;
        end
        `VVT_ADDR_VBLANK_START: begin
          vblank_start_line <= reg_wdata_i;
        end
        `VVT_ADDR_FRAME_END: begin
          frame_end_line <= reg_wdata_i;
        end
        `VVT_ADDR_IRQ_LINE: begin
          display_irq_line <= reg_wdata_i;
        end
        `VVT_ADDR_CONTROL: begin
          control <= reg_wdata_i[2:0];
        end
        default: begin
          control <= control;
        end
      endcase
    end
  end

  // Read data, valid the cycle after the read strobe; unmapped reads zero
  always @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `VVT_ADDR_LINE_END: reg_rdata_o <= line_end_value;
        `VVT_ADDR_VSYNC_END: reg_rdata_o <= vsync_end_line;
        `VVT_ADDR_VBLANK_END: reg_rdata_o <= vblank_end_line;
        `VVT_ADDR_VBLANK_START: reg_rdata_o <= vblank_start_line;
        `VVT_ADDR_FRAME_END: reg_rdata_o <= frame_end_line;
        `VVT_ADDR_IRQ_LINE: reg_rdata_o <= display_irq_line;
        `VVT_ADDR_CONTROL: reg_rdata_o <= {13'h0000, control};
        `VVT_ADDR_STATUS: reg_rdata_o <= {12'h000, ~blank_b_o, odd_field, vblank, vsync_state};
        `VVT_ADDR_PENDING: reg_rdata_o <= {5'h00, display_irq_pending, 10'h000};
        `VVT_ADDR_LINE_COUNTER: reg_rdata_o <= line_counter;
        default: reg_rdata_o <= 16'h0000;
      endcase
    end else begin
      reg_rdata_o <= 16'h0000;
    end
  end

  // Pin drivers: sync, direction, composite blank, interrupt, dot count
  always @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      vsync_o <= 1'b1;
      vsync_oe_o <= 1'b0;
      hsync_o <= 1'b1;
      blank_b_o <= 1'b0;
      display_irq_o <= 1'b0;
      dot_counter_o <= 16'h0000;
    end else begin
      vsync_o <= next_vsync;
      vsync_oe_o <= ~ext_video;
      hsync_o <= ~(next_dot == 16'h0000);
      blank_b_o <= ~(hblank_i | vblank);
      display_irq_o <= display_irq_pending;
      dot_counter_o <= next_dot;
    end
  end
endmodule

// ---- bench/vvt_checker.sv ----
`timescale 1ns/1ns
`include "vvt_consts.vh"
module vvt_checker (
  input wire sys_clk_i,
  input wire rst_b_i,
  input wire [31:0] reg_addr_i,
  input wire [15:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [15:0] reg_rdata_o,
  input wire vsync_i,
  input wire vsync_o,
  input wire vsync_oe_o,
  input wire hsync_o,
  input wire hblank_i,
  input wire blank_b_o,
  input wire display_irq_o,
  input wire [15:0] dot_counter_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  // Dot counter pacing and line start
  dot_step_a: assert property ($changed(dot_counter_o) |-> dot_counter_o == $past(dot_counter_o) + 16'h0001 || dot_counter_o == 16'h0000)
    else $error("dot counter jumped");
  dot_pace_a: assert property ($changed(dot_counter_o) |=> $stable(dot_counter_o)[*3])
    else $error("dot counter moved too fast");
  line_start_a: assert property ($fell(hsync_o) |-> dot_counter_o == 16'h0000)
    else $error("line start marker off dot zero");
  // With a zero line end the dot counter rests at zero, so a wrap shows as no change
  vsync_edge_a: assert property ($fell(vsync_o) && vsync_oe_o && $past(vsync_oe_o) |->
    dot_counter_o == 16'h0000 || $changed(dot_counter_o))
    else $error("vertical sync fell off a dot edge");
  // Bus, blank, interrupt and external sync
  rd_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0000)
    else $error("read data outside its cycle");
  blank_comp_a: assert property ($past(hblank_i) |-> !blank_b_o)
    else $error("blank high during horizontal blank");
  irq_clear_a: assert property ($fell(display_irq_o) |-> $past(reg_wr_i, 2) && $past(reg_addr_i, 2) ==
    `VVT_ADDR_PENDING && ($past(reg_wdata_i, 2) & 16'h0400) == 16'h0000)
    else $error("interrupt dropped without a clear");
  ext_follow_a: assert property (!vsync_oe_o && $fell(vsync_i) |-> ##[1:5] !vsync_o)
    else $error("vertical sync input not followed");
  cover property ($fell(vsync_o));
  cover property ($fell(display_irq_o));
  cover property (!vsync_oe_o && $rose(vsync_i));
  cover property (vsync_oe_o && $rose(vsync_o) && dot_counter_o != 16'h0000);
endmodule

// ---- bench/vvt_video_source.sv ----
`timescale 1ns/1ns
module vvt_video_source (
  output reg video_clock_o,
  output reg hsync_o,
  output reg vsync_o
);
  // Free-running video clock, phase unrelated to the system clock
  initial begin
    video_clock_o = 1'b1;
    hsync_o = 1'b1;
    vsync_o = 1'b1;
    #137;
    forever #200 video_clock_o = ~video_clock_o;
  end
  // Line-rate horizontal sync from the far side
  always begin
    repeat (40) @(negedge video_clock_o);
    hsync_o = 1'b0;
    repeat (4) @(negedge video_clock_o);
    hsync_o = 1'b1;
  end
  // External vertical sync pulse, fall then rise
  task vsync_pulse;
    begin
      @(negedge video_clock_o);
      vsync_o = 1'b0;
      repeat (8) @(negedge video_clock_o);
      vsync_o = 1'b1;
    end
  endtask
endmodule

// ---- bench/tb.sv ----
`timescale 1ns/1ns
`include "vvt_consts.vh"
module tb;
  reg sys_clk_i = 1'b0;
  reg rst_b_i = 1'b0;
  reg [31:0] reg_addr_i = 32'h00000000;
  reg [15:0] reg_wdata_i = 16'h0000;
  reg reg_wr_i = 1'b0;
  reg reg_rd_i = 1'b0;
  reg hblank_i = 1'b0;
  wire [15:0] reg_rdata_o;
  wire [15:0] dot_counter_o;
  wire video_clock_i, vsync_i, hsync_i, vsync_o, vsync_oe_o, hsync_o, blank_b_o, display_irq_o;
  int mismatches = 0;
  int total_checks = 0;
  int n, mask;
  reg [31:0] ra [0:5] = '{`VVT_ADDR_LINE_END, `VVT_ADDR_VSYNC_END, `VVT_ADDR_VBLANK_END,
    `VVT_ADDR_VBLANK_START, `VVT_ADDR_FRAME_END, `VVT_ADDR_IRQ_LINE};
  reg [15:0] rv [0:5] = '{16'h0003, 16'h0001, 16'h0002, 16'h0005, 16'h0006, 16'h0004};
  vvt_video_source i_src (.video_clock_o(video_clock_i), .hsync_o(hsync_i), .vsync_o(vsync_i));
  vvt_vertical_timing i_dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .video_clock_i(video_clock_i), .vsync_i(vsync_i), .vsync_o(vsync_o), .vsync_oe_o(vsync_oe_o),
    .hsync_i(hsync_i), .hsync_o(hsync_o), .hblank_i(hblank_i), .blank_b_o(blank_b_o),
    .display_irq_o(display_irq_o), .dot_counter_o(dot_counter_o));
  initial forever #25 sys_clk_i = ~sys_clk_i;
  // Horizontal blank on the last dot of a short line
  always @(posedge sys_clk_i) hblank_i <= dot_counter_o == 16'h0003;
  task finish_test;
    if (mismatches == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string what, input [31:0] exp, input [31:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task step;
    @(posedge sys_clk_i);
    #1;
  endtask
  function logic sig(input int s);
    sig = s == 0 ? hsync_o : s == 1 ? vsync_o : s == 2 ? display_irq_o : video_clock_i;
  endfunction
  // Bounded wait for a level on a watched signal
  task wait_sig(input int s, input logic v);
    int i;
    for (i = 0; i < 2000 && sig(s) !== v; i++) step;
    if (i == 2000) begin
      chk("wait bound", 1, 0);
      finish_test;
    end
  endtask
  // Register bus cycles
  task wr(input [31:0] a, input [15:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    step;
    reg_wr_i <= 1'b0;
    step;
  endtask
  task rd(input [31:0] a, input [15:0] e, input string what);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    step;
    reg_rd_i <= 1'b0;
    chk(what, e, reg_rdata_o);
    step;
  endtask
  task t_regs;
    int k;
    for (k = 0; k < 6; k++) rd(ra[k], 16'h0000, "reset value");
    for (k = 0; k < 6; k++) wr(ra[k], rv[k]);
    for (k = 0; k < 6; k++) rd(ra[k], rv[k], "timing register");
    rd(32'hC0000100, 16'h0000, "unmapped read");
  endtask
  // One field from a vertical sync fall to the next
  task t_frame;
    int i;
    reg pv, ph;
    n = -1;
    mask = 0;
    pv = vsync_o;
    ph = hsync_o;
    for (i = 0; i < 1000 && n < 99; i++) begin
      step;
      if (n >= 0 && ph && !hsync_o) n++;
      if (n >= 0 && !pv && vsync_o) chk("sync end line", 2, n);
      if (n >= 0 && n < 99 && dot_counter_o === 16'h0002) mask[n] = blank_b_o;
      if (pv && !vsync_o && n >= 0) begin
        chk("lines per field", 7, n);
        n = 99;
      end
      if (pv && !vsync_o && n < 0) begin
        chk("dot at frame start", 0, dot_counter_o);
        chk("hsync with vsync", 0, hsync_o);
        n = 0;
      end
      pv = vsync_o;
      ph = hsync_o;
    end
    if (n != 99) begin
      chk("field bound", 1, 0);
      finish_test;
    end
    chk("visible lines", 32'h38, mask);
  endtask
  task t_irq;
    wr(`VVT_ADDR_PENDING, 16'h0000);
    rd(`VVT_ADDR_PENDING, 16'h0000, "pending cleared");
    wait_sig(2, 1'b1);
    wait_sig(3, 1'b1);
    rd(`VVT_ADDR_LINE_COUNTER, 16'h0004, "line at interrupt");
    wr(`VVT_ADDR_PENDING, 16'hFFFF);
    rd(`VVT_ADDR_PENDING, 16'h0400, "pending sticky");
    wr(`VVT_ADDR_PENDING, 16'h0000);
  endtask
  // Interlaced: even field end and odd sync end fall on the half line
  // Half of line end 3 is dot 1, and the counter steps on to dot 2 at that edge
  task t_lace;
    wr(`VVT_ADDR_CONTROL, 16'h0007);
    wait_sig(1, 1'b0);
    chk("even field end dot", 16'h0002, dot_counter_o);
    wait_sig(1, 1'b1);
    chk("odd sync end dot", 16'h0002, dot_counter_o);
    wait_sig(1, 1'b0);
    chk("odd field end dot", 16'h0000, dot_counter_o);
    wait_sig(1, 1'b1);
    chk("even sync end dot", 16'h0000, dot_counter_o);
    wr(`VVT_ADDR_CONTROL, 16'h0006);
  endtask
  task t_ext;
    wr(`VVT_ADDR_FRAME_END, 16'h0064);
    wr(`VVT_ADDR_LINE_END, 16'h0028);
    wr(`VVT_ADDR_VSYNC_END, 16'h0003);
    wr(`VVT_ADDR_CONTROL, 16'h0000);
    chk("vsync drive", 0, vsync_oe_o);
    wait_sig(0, 1'b0);
    wait_sig(3, 1'b1);
    wr(`VVT_ADDR_LINE_COUNTER, 16'h0030);
    rd(`VVT_ADDR_LINE_COUNTER, 16'h0030, "line written");
    wait_sig(0, 1'b0);
    fork
      i_src.vsync_pulse;
    join_none
    wait_sig(1, 1'b0);
    wait_sig(3, 1'b1);
    rd(`VVT_ADDR_LINE_COUNTER, 16'h0000, "line cleared");
    wait_sig(1, 1'b1);
    // No external pulse: frame end match clears the line one video clock later
    wr(`VVT_ADDR_CONTROL, 16'h0004);
    wait_sig(0, 1'b0);
    wait_sig(3, 1'b1);
    wr(`VVT_ADDR_LINE_COUNTER, 16'h0064);
    wait_sig(0, 1'b1);
    wait_sig(0, 1'b0);
    wait_sig(0, 1'b1);
    wait_sig(3, 1'b1);
    rd(`VVT_ADDR_LINE_COUNTER, 16'h0000, "line cleared late");
  endtask
  initial begin
    repeat (10) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    step;
    t_regs;
    t_frame;
    t_irq;
    t_lace;
    t_ext;
    finish_test;
  end
endmodule
bind vvt_vertical_timing vvt_checker i_chk (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .vsync_i(vsync_i), .vsync_o(vsync_o), .vsync_oe_o(vsync_oe_o), .hsync_o(hsync_o), .hblank_i(hblank_i),
  .blank_b_o(blank_b_o), .display_irq_o(display_irq_o), .dot_counter_o(dot_counter_o));
